// ### hdl/rate_scaler.sv
// rate running average, offset, decimal point checks and output line
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module rate_scaler
    import rate_pkg::*;
#(
    parameter int unsigned FLASH_LEN = FLASH_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [19:0] rate_in,
    input wire logic rate_valid_in,
    input wire logic key_up_in,
    input wire logic key_right_in,
    input wire logic key_menu_in,
    output logic [2:0] flash_digit_out,
    output logic flash_on_out,
    output logic [5:0] cal_step_out,
    output logic [19:0] averaged_rate_out,
    output logic [20:0] rate_display_out,
    output logic signed [20:0] analog_out,
    output logic irq_out
);
    logic rst_meta_q;
    logic rst_sync_q;
    wire logic rst_n = rst_sync_q;

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // register file
    logic [4:0] average_config_q;
    logic [2:0] rate_decimal_position_q;
    logic [19:0] rate_offset_q;
    logic [19:0] sp_q [N_SP];
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;
    logic [31:0] rdata_q;
    logic [ST_W-1:0] ev;

    wire logic wr_ctrl = wr_in && addr_in == OFF_CTRL;
    wire logic wr_dp = wr_in && addr_in == OFF_DP;
    wire logic wr_ofs = wr_in && addr_in == OFF_OFFSET;
    wire logic wr_st = wr_in && addr_in == OFF_STATUS;
    wire logic wr_mask = wr_in && addr_in == OFF_MASK;
    wire logic [2:0] dp_new = wdata_in[2:0];
    wire logic [19:0] lim_new = dp_limit(dp_new);
    wire logic ofs_fits = rate_offset_q <= lim_new;
    wire logic dp_ok = wr_dp && dp_new <= DP_MAX && ofs_fits;
    wire logic dp_refused = wr_dp && !dp_ok;
    wire logic filter_type_sel = average_config_q[CTRL_FTYPE_BIT];
    wire logic [3:0] avg_code = average_config_q[CTRL_CODE_LSB +: 4];
    logic [N_SP-1:0] sp_over;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            average_config_q <= CTRL_RST;
            rate_decimal_position_q <= DP_RST;
            rate_offset_q <= OFFSET_RST;
            mask_q <= '0;
        end else begin
            if (wr_ctrl) average_config_q <= wdata_in[4:0];
            if (dp_ok) rate_decimal_position_q <= dp_new;
            if (wr_ofs) rate_offset_q <= wdata_in[19:0];
            if (wr_mask) mask_q <= wdata_in[ST_W-1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_SP; g++) begin : g_sp
            assign sp_over[g] = sp_q[g] > lim_new;
            always_ff @(posedge clock_in or negedge rst_n) begin
                if (!rst_n) begin
                    sp_q[g] <= SP_RST;
                end else if (dp_ok && sp_over[g]) begin
                    sp_q[g] <= lim_new;
                end else if (wr_in && addr_in == OFF_SP0 + 8'(4 * g)) begin
                    sp_q[g] <= wdata_in[19:0];
                end
            end
        end
    endgenerate

    // a hardware event in the clearing cycle keeps its bit set
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(wr_st ? wdata_in[ST_W-1:0] : '0)) | ev;
        end
    end

    // running average, Q16 accumulator
    logic signed [39:0] acc_q;
    logic [3:0] work_k_q;
    logic [1:0] trend_q;
    logic [3:0] calm_q;
    logic last_neg_q;

    wire logic [3:0] max_k = (avg_code > 4'h8) ? AVG_MAX_K
                                               : avg_code + AVG_BASE_K;
    wire logic [3:0] eff_k = filter_type_sel ? max_k : work_k_q;
    wire logic signed [39:0] x_ext = $signed({4'h0, rate_in, 16'h0000});
    wire logic signed [39:0] diff = x_ext - acc_q;
    wire logic signed [39:0] acc_d = acc_q + (diff >>> eff_k);
    wire logic [39:0] diff_abs = diff[39] ? 40'(-diff) : 40'(diff);
    wire logic big = diff_abs[39:16] > ADAPT_THRESH;
    wire logic same = big && diff[39] == last_neg_q && trend_q != 2'h0;
    wire logic [1:0] trend_inc = same ? trend_q + 2'h1 : {1'b0, big};
    wire logic shrink = trend_inc == TREND_RUN && work_k_q != 4'h0;
    wire logic grow = !big && calm_q == CALM_RUN - 4'h1 && work_k_q < max_k;
    wire logic [19:0] avg_val = acc_q[35:16];
    logic [3:0] work_k_d;

    always_comb begin
        work_k_d = work_k_q;
        if (rate_valid_in && !filter_type_sel) begin
            if (shrink) work_k_d = work_k_q - 4'h1;
            else if (grow) work_k_d = work_k_q + 4'h1;
        end
        if (work_k_d > max_k) work_k_d = max_k;
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= '0;
            work_k_q <= 4'h0;
            trend_q <= 2'h0;
            calm_q <= 4'h0;
            last_neg_q <= 1'b0;
        end else begin
            work_k_q <= work_k_d;
            if (rate_valid_in) begin
                acc_q <= acc_d;
                trend_q <= shrink ? 2'h0 : trend_inc;
                calm_q <= (big || grow) ? 4'h0 : calm_q + 4'h1;
                last_neg_q <= diff[39];
            end
        end
    end

    // offset on the averaged rate, feeding both the display and the output line
    wire logic [20:0] disp = {1'b0, avg_val} + {1'b0, rate_offset_q};

    // keypad entry of the two calibration points
    entry_if ent ();
    assign ent.up = key_up_in;
    assign ent.right = key_right_in;
    assign ent.menu = key_menu_in;

    digit_entry #(.FLASH_LEN(FLASH_LEN)) u_entry (
        .clk(clock_in),
        .rst_n(rst_n),
        .e(ent)
    );

    cal_state_t cal_q;
    logic [19:0] read_tmp_q;
    logic [19:0] read1_q;
    logic [19:0] out1_q;
    logic [19:0] read2_q;
    logic [19:0] out2_q;
    logic [NUM_W-1:0] num_q;
    logic [NUM_W-1:0] quo_q;
    logic [20:0] rem_q;
    logic [19:0] den_q;
    logic neg_q;
    logic [5:0] cnt_q;
    logic div_run_q;
    logic signed [31:0] slope_q;
    logic signed [39:0] icpt_q;

    wire logic signed [20:0] d_out = $signed({1'b0, out2_q})
                                   - $signed({1'b0, out1_q});
    wire logic signed [20:0] d_read = $signed({1'b0, read2_q})
                                    - $signed({1'b0, read1_q});
    wire logic [20:0] d_out_abs = d_out[20] ? 21'(-d_out) : 21'(d_out);
    wire logic [20:0] d_read_abs = d_read[20] ? 21'(-d_read) : 21'(d_read);
    wire logic [20:0] rem_sh = {rem_q[19:0], num_q[NUM_W-1]};
    wire logic rem_ge = rem_sh >= {1'b0, den_q};
    wire logic div_zero = den_q == 20'h0;
    wire logic signed [31:0] slope_new = div_zero ? 32'sh0
        : (neg_q ? 32'(-$signed({1'b0, quo_q[30:0]}))
                 : $signed({1'b0, quo_q[30:0]}));
    wire logic signed [52:0] icpt_prod = slope_new * $signed({1'b0, read1_q});
    wire logic signed [39:0] icpt_new = $signed({4'h0, out1_q, 16'h0000})
                                      - icpt_prod[39:0];

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            cal_q <= CAL_READ1;
            read_tmp_q <= 20'h0;
            read1_q <= DEF_READ1;
            out1_q <= DEF_OUT1;
            read2_q <= DEF_READ2;
            out2_q <= DEF_OUT2;
        end else begin
            case (cal_q)
                CAL_READ1: if (ent.store) begin
                    read_tmp_q <= ent.value;
                    cal_q <= CAL_OUT1;
                end
                CAL_OUT1: if (ent.store) begin
                    read1_q <= read_tmp_q;
                    out1_q <= ent.value;
                    cal_q <= CAL_READ2;
                end
                CAL_READ2: if (ent.store) begin
                    read_tmp_q <= ent.value;
                    cal_q <= CAL_OUT2;
                end
                CAL_OUT2: if (ent.store) begin
                    read2_q <= read_tmp_q;
                    out2_q <= ent.value;
                    cal_q <= CAL_DIV;
                end
                CAL_DIV: if (cnt_q == DIV_STEPS) cal_q <= CAL_ICPT;
                CAL_ICPT: cal_q <= CAL_READ1;
                default: cal_q <= CAL_READ1;
            endcase
        end
    end

    // restoring divider; reloads in its first cycle, once the points commit
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            num_q <= '0;
            quo_q <= '0;
            rem_q <= '0;
            den_q <= '0;
            neg_q <= 1'b0;
            cnt_q <= 6'h0;
            div_run_q <= 1'b0;
        end else if (cal_q != CAL_DIV || !div_run_q) begin
            num_q <= {d_out_abs[19:0], 16'h0000};
            den_q <= d_read_abs[19:0];
            neg_q <= d_out[20] ^ d_read[20];
            quo_q <= '0;
            rem_q <= '0;
            cnt_q <= 6'h0;
            div_run_q <= cal_q == CAL_DIV;
        end else if (cnt_q != DIV_STEPS) begin
            num_q <= num_q << 1;
            rem_q <= rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
            quo_q <= {quo_q[NUM_W-2:0], rem_ge};
            cnt_q <= cnt_q + 6'h1;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            slope_q <= SLOPE_RST;
            icpt_q <= ICPT_RST;
        end else if (cal_q == CAL_ICPT) begin
            slope_q <= slope_new;
            icpt_q <= icpt_new;
        end
    end

    // output line, refreshed every cycle
    wire logic signed [53:0] line_prod = $signed({1'b0, disp}) * slope_q;
    wire logic signed [53:0] line_sum = line_prod + 54'(icpt_q);
    wire logic signed [53:0] line_val = line_sum >>> FRAC;
    logic signed [20:0] analog_q;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            analog_q <= '0;
        end else begin
            analog_q <= line_val[20:0];
        end
    end

    always_comb begin
        ev = '0;
        ev[ST_AVG] = rate_valid_in;
        ev[ST_SP_CLAMP] = dp_ok && (|sp_over);
        ev[ST_OFS_ERR] = dp_refused;
        ev[ST_CAL_DONE] = cal_q == CAL_ICPT;
        ev[ST_CAL_ERR] = cal_q == CAL_ICPT && div_zero;
    end

    wire logic [31:0] rd_mux =
        (addr_in == OFF_CTRL) ? {27'h0, average_config_q} :
        (addr_in == OFF_DP) ? {29'h0, rate_decimal_position_q} :
        (addr_in == OFF_OFFSET) ? {12'h0, rate_offset_q} :
        (addr_in == OFF_SP0) ? {12'h0, sp_q[0]} :
        (addr_in == OFF_SP0 + 8'h04) ? {12'h0, sp_q[1]} :
        (addr_in == OFF_STATUS) ? {27'h0, status_q} :
        (addr_in == OFF_MASK) ? {27'h0, mask_q} :
        (addr_in == OFF_AVG) ? {12'h0, avg_val} :
        (addr_in == OFF_OUT) ? 32'(analog_q) :
        (addr_in == OFF_SLOPE) ? slope_q :
        (addr_in == OFF_ICPT) ? icpt_q[39:8] :
        (addr_in == OFF_WORK) ? {28'h0, eff_k} : 32'h0;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) rdata_q <= 32'h0;
        else rdata_q <= rd_in ? rd_mux : 32'h0;
    end

    assign rdata_out = rdata_q;
    assign irq_out = |(status_q & mask_q);
    assign flash_digit_out = ent.digit_idx;
    assign flash_on_out = ent.flash;
    assign cal_step_out = cal_q;
    assign averaged_rate_out = avg_val;
    assign rate_display_out = disp;
    assign analog_out = analog_q;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n);

    property p_k_bound;
        $stable(average_config_q) |-> work_k_q <= max_k;
    endproperty
    a_k_bound: assert property (p_k_bound) else $error("length over max");

    property p_shrink;
        (rate_valid_in && !filter_type_sel && shrink)
            |=> work_k_q == $past(work_k_q) - 4'h1;
    endproperty
    a_shrink: assert property (p_shrink) else $error("no shrink");

    property p_grow;
        (rate_valid_in && !filter_type_sel && !shrink && grow)
            |=> work_k_q == $past(work_k_q) + 4'h1;
    endproperty
    a_grow: assert property (p_grow) else $error("no growth");

    property p_fixed_rise;
        (filter_type_sel && rate_valid_in && !diff[39])
            |=> acc_q >= $past(acc_q);
    endproperty
    a_fixed_rise: assert property (p_fixed_rise) else $error("avg fell");

    property p_line;
        1'b1 |=> analog_q == $past(line_val[20:0]);
    endproperty
    a_line: assert property (p_line) else $error("output off line");

    sequence s_out1_commit;
        cal_q == CAL_OUT1 && ent.store;
    endsequence
    sequence s_second_point;
        cal_q == CAL_READ2 && read1_q == $past(read_tmp_q);
    endsequence
    property p_cal_order;
        s_out1_commit |=> s_second_point;
    endproperty
    a_cal_order: assert property (p_cal_order) else $error("cal order");

    property p_dp_refuse;
        dp_refused |=> $stable(rate_decimal_position_q)
                       && status_q[ST_OFS_ERR];
    endproperty
    a_dp_refuse: assert property (p_dp_refuse) else $error("dp taken");

    property p_sp_clamp;
        (dp_ok && sp_over[0]) |=> sp_q[0] == $past(lim_new)
                                  && status_q[ST_SP_CLAMP];
    endproperty
    a_sp_clamp: assert property (p_sp_clamp) else $error("no clamp");

    property p_offset_only;
        1'b1 |-> rate_display_out == 21'(avg_val) + 21'(rate_offset_q);
    endproperty
    a_offset_only: assert property (p_offset_only) else $error("offset");
endmodule

// ### hdl/rate_pkg.sv
// constants, register map and types of the rate averaging block
package rate_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int VAL_W = 20;
    localparam int FRAC = 16;
    localparam int DIGITS = 6;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DP = 8'h04;
    localparam logic [7:0] OFF_OFFSET = 8'h08;
    localparam logic [7:0] OFF_SP0 = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_AVG = 8'h1c;
    localparam logic [7:0] OFF_OUT = 8'h20;
    localparam logic [7:0] OFF_SLOPE = 8'h24;
    localparam logic [7:0] OFF_ICPT = 8'h28;
    localparam logic [7:0] OFF_WORK = 8'h2c;
    localparam int N_SP = 2;

    // control fields: {filter_type_sel, a, b, c, d}
    localparam int CTRL_CODE_LSB = 0;
    localparam int CTRL_FTYPE_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h01;
    localparam logic [3:0] AVG_BASE_K = 4'h7;
    localparam logic [3:0] AVG_MAX_K = 4'hf;

    // adaptive filter tuning
    localparam logic [1:0] TREND_RUN = 2'h3;
    localparam logic [3:0] CALM_RUN = 4'h8;
    localparam logic [23:0] ADAPT_THRESH = 24'h000010;

    // factory calibration, output in microamps
    localparam logic [19:0] DEF_READ1 = 20'h00000;
    localparam logic [19:0] DEF_OUT1 = 20'h00fa0;
    localparam logic [19:0] DEF_READ2 = 20'h02710;
    localparam logic [19:0] DEF_OUT2 = 20'h04e20;
    localparam logic signed [31:0] SLOPE_RST = 32'(
        (longint'(DEF_OUT2 - DEF_OUT1) <<< FRAC)
        / longint'(DEF_READ2 - DEF_READ1));
    localparam logic signed [39:0] ICPT_RST = 40'(
        (longint'(DEF_OUT1) <<< FRAC)
        - longint'(SLOPE_RST) * longint'(DEF_READ1));

    localparam logic [2:0] DP_RST = 3'h0;
    localparam logic [2:0] DP_MAX = 3'h5;
    localparam logic [19:0] OFFSET_RST = 20'h00000;
    localparam logic [19:0] SP_RST = 20'h00000;

    // status bits
    localparam int ST_AVG = 0;
    localparam int ST_SP_CLAMP = 1;
    localparam int ST_OFS_ERR = 2;
    localparam int ST_CAL_DONE = 3;
    localparam int ST_CAL_ERR = 4;
    localparam int ST_W = 5;

    localparam int NUM_W = 36;
    localparam logic [5:0] DIV_STEPS = 6'h24;

    // digit flash half period
    localparam int FLASH_HALF_MS = 250;
    localparam int CLK_MHZ = 200;
    localparam int FLASH_CYCLES = FLASH_HALF_MS * 1000 * CLK_MHZ;

    typedef enum logic [5:0] {
        CAL_READ1 = 6'b000001,
        CAL_OUT1 = 6'b000010,
        CAL_READ2 = 6'b000100,
        CAL_OUT2 = 6'b001000,
        CAL_DIV = 6'b010000,
        CAL_ICPT = 6'b100000
    } cal_state_t;

    // largest whole value with dp places taken from five digits
    function automatic logic [19:0] dp_limit(input logic [2:0] dp);
        case (dp)
            3'h0: dp_limit = 20'h1869f;
            3'h1: dp_limit = 20'h0270f;
            3'h2: dp_limit = 20'h003e7;
            3'h3: dp_limit = 20'h00063;
            3'h4: dp_limit = 20'h00009;
            default: dp_limit = 20'h00000;
        endcase
    endfunction
endpackage

// ### hdl/entry_if.sv
// keypad digit entry signals between the editor and its owner
`timescale 1ns/1ps
interface entry_if;
    logic up;
    logic right;
    logic menu;
    logic store;
    logic [2:0] digit_idx;
    logic flash;
    logic [19:0] value;
    modport editor(input up, right, menu,
                   output store, digit_idx, flash, value);
    modport owner(output up, right, menu,
                  input store, digit_idx, flash, value);
endinterface

// ### hdl/digit_entry.sv
// six digit numeric entry: flashing digit, increment, move, store
`timescale 1ns/1ps
module digit_entry
    import rate_pkg::*;
#(
    parameter int unsigned FLASH_LEN = FLASH_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    entry_if.editor e
);
    logic [3:0] dig_q [DIGITS];
    logic [2:0] idx_q;
    logic store_q;
    logic [19:0] value_q;
    logic [31:0] flash_cnt_q;
    logic flash_q;

    wire logic flash_wrap = flash_cnt_q == 32'(FLASH_LEN - 1);
    wire logic [2:0] idx_next = (idx_q == 3'(DIGITS - 1)) ? 3'h0
                                                         : idx_q + 3'h1;

    function automatic logic [19:0] to_bin(input logic [3:0] d [DIGITS]);
        logic [23:0] acc;
        acc = 24'h0;
        for (int i = 0; i < DIGITS; i++) begin
            acc = 24'(acc * 24'h00000a) + 24'(d[i]);
        end
        to_bin = acc[19:0];
    endfunction

    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : g_dig
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dig_q[g] <= 4'h0;
                end else if (e.menu) begin
                    dig_q[g] <= 4'h0;
                end else if (e.up && idx_q == 3'(g)) begin
                    dig_q[g] <= (dig_q[g] == 4'h9) ? 4'h0 : dig_q[g] + 4'h1;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 3'h0;
            store_q <= 1'b0;
            value_q <= 20'h0;
        end else begin
            store_q <= e.menu;
            if (e.menu) begin
                idx_q <= 3'h0;
                value_q <= to_bin(dig_q);
            end else if (e.right) begin
                idx_q <= idx_next;
            end
        end
    end

    // restart the blink on each move so the new digit shows at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_q <= 32'h0;
            flash_q <= 1'b1;
        end else if (e.right || e.menu || flash_wrap) begin
            flash_cnt_q <= 32'h0;
            flash_q <= (e.right || e.menu) ? 1'b1 : ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    assign e.store = store_q;
    assign e.value = value_q;
    assign e.digit_idx = idx_q;
    assign e.flash = flash_q;

    property p_up_inc;
        @(posedge clk) disable iff (!rst_n)
        (e.up && !e.menu && dig_q[0] != 4'h9 && idx_q == 3'h0)
            |=> dig_q[0] == $past(dig_q[0]) + 4'h1;
    endproperty
    a_up_inc: assert property (p_up_inc) else $error("digit not incremented");

    property p_menu_store;
        @(posedge clk) disable iff (!rst_n)
        e.menu |=> store_q && idx_q == 3'h0 ##1 !store_q || $past(e.menu);
    endproperty
    a_menu_store: assert property (p_menu_store) else $error("menu not stored");
endmodule

// ### tb/keypad_model.sv
// front panel keypad model: one-cycle key pulses
`timescale 1ns/1ps
module keypad_model (
    input wire logic clk,
    output logic up_out,
    output logic right_out,
    output logic menu_out
);
    initial {up_out, right_out, menu_out} = 3'h0;
    task automatic press(input logic [2:0] k);
        @(posedge clk);
        {up_out, right_out, menu_out} <= k;
        @(posedge clk);
        {up_out, right_out, menu_out} <= 3'h0;
    endtask
    // six digits, most significant first
    task automatic enter(input int v);
        int d;
        for (int i = 0; i < 6; i++) begin
            d = (v / (10 ** (5 - i))) % 10;
            repeat (d) press(3'h4);
            if (i < 5) press(3'h2);
        end
        press(3'h1);
    endtask
endmodule

// ### tb/tb.sv
// testbench of the rate scaler
`timescale 1ns/1ps
module tb;
    import rate_pkg::*;
    logic clk, rst_n, wr, rd, rv, up, right, menu, irq;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, r;
    logic [19:0] rate, avg;
    logic [20:0] disp;
    logic signed [20:0] aout;
    logic [5:0] step;
    logic [2:0] fdig;
    logic fon;
    int mismatches, samples_checked;
    rate_scaler #(.FLASH_LEN(8)) i_rate_scaler(.clock_in(clk),
        .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rate_in(rate),
        .rate_valid_in(rv), .key_up_in(up), .key_right_in(right),
        .key_menu_in(menu), .flash_digit_out(fdig), .flash_on_out(fon),
        .cal_step_out(step), .averaged_rate_out(avg),
        .rate_display_out(disp), .analog_out(aout), .irq_out(irq));
    keypad_model i_keypad_model(.clk(clk), .up_out(up),
        .right_out(right), .menu_out(menu));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 r = rdata;
    endtask
    task automatic smp(input logic [19:0] v);
        @(posedge clk);
        rate <= v;
        rv <= 1'b1;
        @(posedge clk);
        rv <= 1'b0;
        #1;
    endtask
    task automatic cal(input int v, input logic [5:0] s);
        i_keypad_model.enter(v);
        repeat (3) @(posedge clk);
        #1 chk(step, s);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
    initial begin
        {rst_n, wr, rd, rv} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0;
        rate = 20'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdr(OFF_CTRL); chk(r, 32'h1);
        rdr(OFF_DP); chk(r, 32'h0);
        rdr(OFF_OFFSET); chk(r, 32'h0);
        rdr(OFF_OUT); chk(r, 32'hfa0);
        // reverse acting line: 20000 at 0 down to 4000 at 10000
        cal(0, 6'h02);
        cal(20000, 6'h04);
        cal(10000, 6'h08);
        cal(4000, 6'h10);
        repeat (50) @(posedge clk);
        #1 chk(32'(aout), 32'd20000);
        rdr(OFF_SLOPE); chk(r, 32'hfffe6667);
        smp(20'd10000); chk(avg, 32'd10000);
        // eight calm samples lengthen, three rising ones shorten
        repeat (8) smp(20'd10000);
        rdr(OFF_WORK); chk(r, 32'h1);
        repeat (3) smp(20'd20000);
        rdr(OFF_WORK); chk(r, 32'h0);
        smp(20'd10000); chk(avg, 32'd10000);
        @(posedge clk);
        #1 chk(32'(aout), 32'd4000);
        wrr(OFF_SP0, 32'd20000);
        wrr(OFF_DP, 32'h1);
        rdr(OFF_SP0); chk(r, 32'h270f);
        wrr(OFF_OFFSET, 32'd1000);
        wrr(OFF_DP, 32'h2);
        rdr(OFF_DP); chk(r, 32'h1);
        rdr(OFF_STATUS); chk(32'(r[2:1]), 32'h3);
        chk(disp, 32'd11000);
        wrr(OFF_MASK, 32'h4);
        #1 chk(irq, 1'b1);
        wrr(OFF_STATUS, 32'h4);
        #1 chk(irq, 1'b0);
        wrr(OFF_CTRL, 32'h10);
        smp(20'd22800);
        // shortest fixed length is 128 values: a 12800 step moves by 100
        chk(avg, 32'd10100);
        i_keypad_model.press(3'h4);
        i_keypad_model.press(3'h2);
        #1 chk(fdig, 32'h1);
        chk(fon, 32'h1);
        repeat (8) @(posedge clk);
        #1 chk(fon, 32'h0);
        complete_run;
    end
endmodule
